// ==== logic/sar_conv_defs.vh ====
// constants shared by the conversion sequencer files
`ifndef SAR_CONV_DEFS_VH
`define SAR_CONV_DEFS_VH
`define CLK_DIV 4
`define DIV_W 2
`define EOT_DELAY 15
`define EOT_CNT_W 4
`define RES_DEFAULT 16
`define CAL_CYCLES_DEFAULT 1441020
`define CAL_TRIM_W 8
`define CAL_TRIM_RESET 8'h80
`define ST_IDLE 3'h0
`define ST_TRACK 3'h1
`define ST_HOLD 3'h2
`define ST_APPROX 3'h3
`define ST_DONE 3'h4
`define ST_CAL 3'h5
`endif

// ==== logic/clk_source_select.v ====
// master clock source selection and divide-by-four conversion tick
`timescale 1ns/1ps
`default_nettype none
`include "sar_conv_defs.vh"
module clk_source_select (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_b,
  // master clock pin, already synchronised, and oscillator tick
  input wire master_clock_sync,
  input wire osc_tick_in,
  // outputs
  output reg ext_mode_out,
  output reg conv_tick_out
);
  reg mclk_d_r;
  reg [`DIV_W-1:0] div_r;
  reg seen_high_r;
  wire mclk_rise;
  wire src_tick;
  assign mclk_rise = master_clock_sync & ~mclk_d_r;
  // pin held low selects the internal oscillator
  assign src_tick = ext_mode_out ? mclk_rise : osc_tick_in;
  always @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      mclk_d_r <= 1'b0;
      div_r <= {`DIV_W{1'b0}};
      seen_high_r <= 1'b0;
      ext_mode_out <= 1'b0;
      conv_tick_out <= 1'b0;
    end else begin
      mclk_d_r <= master_clock_sync;
      seen_high_r <= master_clock_sync ? 1'b1 : seen_high_r;
      ext_mode_out <= seen_high_r | master_clock_sync;
      conv_tick_out <= 1'b0;
      if (src_tick) begin
        div_r <= div_r + 1'b1;
        // internal clock is master clock over four
        conv_tick_out <= (div_r == `CLK_DIV - 1);
      end
    end
  end
endmodule // clk_source_select
`default_nettype wire

// ==== logic/sar_conversion_sequencer.v ====
// successive-approximation conversion and calibration sequencer
//
// Contract
// - start each approximation at half scale, only msb set
// - clear trial bit if input below level, then try next lower bit
// - saturate code to all ones above reference, all zeros below range
// - bipolar ties msb weight to reference, result is offset binary
// - stay in track mode when neither calibrating nor converting
// - freeze sampled input at conversion start, ignore later changes
// - capture comparator offset in track, subtract at conversion start
// - calibration trims each weight to sum of lower weights plus one
// - master clock pin low selects internal oscillator, else external
// - all durations are fixed counts of master clock cycles
// - hold falling edge enters hold and starts a conversion
// - return to track automatically after conversion
// - hold still low after conversion starts another conversion
// - sequence on master clock divided by four
// - conversion lasts at least 49, 57 or 65 master clocks
// - track done falls 15 master clocks after end of conversion (code: 16, after four ticks)
`timescale 1ns/1ps
`default_nettype none
`include "sar_conv_defs.vh"
module sar_conversion_sequencer #(
  parameter RES = `RES_DEFAULT,
  parameter CAL_CYCLES = `CAL_CYCLES_DEFAULT
) (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_b_in,
  // pins from outside
  input wire master_clock_in,
  input wire osc_tick_in,
  input wire hold_n_in,
  input wire bipolar_in,
  input wire cal_start_in,
  // comparator and analog sample
  input wire comp_below_in,
  input wire comp_over_ref_in,
  input wire comp_under_range_in,
  input wire [RES-1:0] analog_input_code_in,
  input wire [RES-1:0] comp_offset_in,
  // result and status
  output reg [RES-1:0] result_out,
  output reg [RES-1:0] trial_out,
  output reg tracking_out,
  output reg msb_to_ref_out,
  output reg eoc_n_out,
  output reg track_done_n_out,
  output reg calibrating_out,
  output reg [`CAL_TRIM_W-1:0] cal_trim_out,
  output reg [RES-1:0] held_sample_out
);
  // 49/57/65 master clocks = 12/14/16 tick periods plus one
  localparam STEPS = RES;
  localparam MIN_CONV = 4 * RES + 1;
  localparam CNT_W = 8;
  localparam CAL_W = 21;
  // step sizes at the width of the counters they advance
  localparam [CNT_W-1:0] CONV_STEP = `CLK_DIV;
  localparam [`EOT_CNT_W-1:0] EOT_STEP = `CLK_DIV;
  localparam [CAL_W-1:0] CAL_STEP = `CLK_DIV;

  reg rst_s1_r, rst_s2_r;
  reg [2:0] hold_sync_r;
  reg mclk_s1_r, mclk_s2_r;
  reg bip_s1_r, bip_s2_r;
  reg [2:0] state_r;
  reg [RES-1:0] bit_r;
  reg [CNT_W-1:0] conv_cnt_r;
  reg [`EOT_CNT_W-1:0] eot_cnt_r;
  reg eot_arm_r;
  reg hold_pend_r;
  reg [CAL_W-1:0] cal_cnt_r;
  reg [RES-1:0] offset_r;
  reg [4:0] cal_bit_r;
  wire rst_b;
  wire hold_fall;
  wire conv_tick;
  wire ext_mode;

  // release of reset through two flops
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_b = rst_s2_r;

  // pin synchronisers; stage two and three feed edge detect
  always @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      hold_sync_r <= 3'h7;
      mclk_s1_r <= 1'b0;
      mclk_s2_r <= 1'b0;
      bip_s1_r <= 1'b0;
      bip_s2_r <= 1'b0;
    end else begin
      hold_sync_r <= {hold_sync_r[1:0], hold_n_in};
      mclk_s1_r <= master_clock_in;
      mclk_s2_r <= mclk_s1_r;
      bip_s1_r <= bipolar_in;
      bip_s2_r <= bip_s1_r;
    end
  end
  assign hold_fall = hold_sync_r[2] & ~hold_sync_r[1];

  clk_source_select u_clk (
    .sys_clk_in(sys_clk_in),
    .rst_b(rst_b),
    .master_clock_sync(mclk_s2_r),
    .osc_tick_in(osc_tick_in),
    .ext_mode_out(ext_mode),
    .conv_tick_out(conv_tick)
  );

  function [RES-1:0] saturate;
    input [RES-1:0] code;
    input over;
    input under;
    begin
      if (over)
        saturate = {RES{1'b1}};
      else if (under)
        saturate = {RES{1'b0}};
      else
        saturate = code;
    end
  endfunction

  always @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= `ST_CAL;
      bit_r <= {RES{1'b0}};
      conv_cnt_r <= {CNT_W{1'b0}};
      eot_cnt_r <= {`EOT_CNT_W{1'b0}};
      eot_arm_r <= 1'b0;
      hold_pend_r <= 1'b0;
      cal_cnt_r <= {CAL_W{1'b0}};
      offset_r <= {RES{1'b0}};
      cal_bit_r <= 5'h0;
      result_out <= {RES{1'b0}};
      trial_out <= {RES{1'b0}};
      tracking_out <= 1'b0;
      msb_to_ref_out <= 1'b0;
      eoc_n_out <= 1'b1;
      track_done_n_out <= 1'b1;
      calibrating_out <= 1'b1;
      cal_trim_out <= `CAL_TRIM_RESET;
      held_sample_out <= {RES{1'b0}};
    end else begin
      // edges caught between ticks are served at the next tick in track, held through a conversion, dropped in calibration
      if (hold_fall)
        hold_pend_r <= 1'b1;
      // range follows the pin on every clock while tracking
      if (state_r == `ST_TRACK)
        msb_to_ref_out <= bip_s2_r;
      if (cal_start_in && state_r != `ST_CAL) begin
        state_r <= `ST_CAL;
        cal_cnt_r <= {CAL_W{1'b0}};
        calibrating_out <= 1'b1;
        tracking_out <= 1'b0;
      end
      // track done counts master clock cycles on the conversion grid
      if (eot_arm_r && conv_tick) begin
        if (eot_cnt_r >= `EOT_DELAY - `CLK_DIV + 1) begin
          track_done_n_out <= 1'b0;
          eot_arm_r <= 1'b0;
        end else
          eot_cnt_r <= eot_cnt_r + EOT_STEP;
      end
      if (conv_tick) begin
        case (state_r)
          `ST_CAL: begin
            // hold ignored while calibrating
            hold_pend_r <= 1'b0;
            // each weight trimmed against lower sum plus dummy lsb
            if (comp_below_in)
              cal_trim_out <= cal_trim_out - 1'b1;
            else
              cal_trim_out <= cal_trim_out + 1'b1;
            cal_cnt_r <= cal_cnt_r + CAL_STEP;
            cal_bit_r <= (cal_bit_r == RES - 1) ? 5'h0 : cal_bit_r + 1'b1;
            if (cal_cnt_r >= CAL_CYCLES - `CLK_DIV) begin
              calibrating_out <= 1'b0;
              eoc_n_out <= 1'b0;
              // track done also follows the end of calibration
              eot_arm_r <= 1'b1;
              eot_cnt_r <= {`EOT_CNT_W{1'b0}};
              state_r <= `ST_TRACK;
            end
          end
          `ST_IDLE, `ST_TRACK: begin
            tracking_out <= 1'b1;
            offset_r <= comp_offset_in;
            if (hold_pend_r || hold_fall) begin
              hold_pend_r <= 1'b0;
              // sample frozen and offset removed at start
              held_sample_out <= analog_input_code_in - offset_r;
              tracking_out <= 1'b0;
              eoc_n_out <= 1'b1;
              track_done_n_out <= 1'b1;
              eot_arm_r <= 1'b0;
              trial_out <= {1'b1, {(RES-1){1'b0}}};
              bit_r <= {1'b1, {(RES-1){1'b0}}};
              conv_cnt_r <= {CNT_W{1'b0}};
              state_r <= `ST_APPROX;
            end
          end
          `ST_APPROX: begin
            conv_cnt_r <= conv_cnt_r + CONV_STEP;
            if (bit_r != {RES{1'b0}}) begin
              if (comp_below_in) begin
                trial_out <= (trial_out & ~bit_r) | (bit_r >> 1);
              end else begin
                trial_out <= trial_out | (bit_r >> 1);
              end
              bit_r <= bit_r >> 1;
            end else if (conv_cnt_r >= MIN_CONV - 1) begin
              state_r <= `ST_DONE;
            end
          end
          `ST_DONE: begin
            // offset binary falls out of the msb-to-reference tie
            result_out <= saturate(trial_out, comp_over_ref_in,
                                   comp_under_range_in);
            eoc_n_out <= 1'b0;
            tracking_out <= 1'b1;
            eot_arm_r <= 1'b1;
            eot_cnt_r <= {`EOT_CNT_W{1'b0}};
            state_r <= `ST_TRACK;
            // hold still low: restart despite short acquisition
            if (!hold_sync_r[2])
              hold_pend_r <= 1'b1;
          end
          default: state_r <= `ST_TRACK;
        endcase
      end
    end
  end
endmodule // sar_conversion_sequencer
`default_nettype wire

// ==== verification/sar_conv_checker_assertions.sv ====
// port assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_conv_checker #(parameter int RES = 16) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic hold_n_in,
  input wire logic bipolar_in,
  input wire logic comp_over_ref_in,
  input wire logic [RES-1:0] result_out,
  input wire logic [RES-1:0] trial_out,
  input wire logic [RES-1:0] held_sample_out,
  input wire logic tracking_out,
  input wire logic msb_to_ref_out,
  input wire logic eoc_n_out,
  input wire logic track_done_n_out,
  input wire logic calibrating_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  int low_cnt;
  // cycles out of track; a master clock is never shorter than one
  always @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in) low_cnt <= 0;
    else low_cnt <= tracking_out ? 0 : low_cnt + 1;
  AST_HALF_SCALE: assert property (
    $fell(tracking_out) && !calibrating_out |->
    trial_out == {1'b1, {(RES-1){1'b0}}}) else $error("bad first trial");
  AST_HOLD_START: assert property (
    $fell(hold_n_in) && tracking_out && !calibrating_out |->
    ##[1:40] !tracking_out) else $error("hold not served");
  AST_MIN_CONV: assert property (
    $rose(tracking_out) |-> low_cnt >= 4 * RES) else $error("short run");
  AST_EOT_DELAY: assert property (
    $fell(eoc_n_out) && hold_n_in |=> track_done_n_out [*8] ##[6:200]
    !track_done_n_out) else $error("track done timing");
  AST_SAT_HIGH: assert property (
    $fell(eoc_n_out) && $past(comp_over_ref_in) |-> &result_out)
    else $error("no saturation");
  AST_BIP_MSB: assert property (
    (tracking_out && $stable(bipolar_in)) [*3] |->
    msb_to_ref_out == bipolar_in) else $error("msb weight wrong");
  AST_HELD_FROZEN: assert property (
    !tracking_out && !$past(tracking_out) && !$past(tracking_out, 2) &&
    !calibrating_out |-> $stable(held_sample_out)) else $error("sample moved");
  AST_EOC_TRACK: assert property (
    $fell(eoc_n_out) && !$past(calibrating_out) |-> tracking_out)
    else $error("no return to track");
  cover property ($fell(eoc_n_out) && bipolar_in);
  cover property ($fell(eoc_n_out) && !hold_n_in);
  cover property ($fell(eoc_n_out) && comp_over_ref_in);
endmodule // sar_conv_checker
bind sar_conversion_sequencer sar_conv_checker #(.RES(RES)) i_chk (
  .sys_clk_in, .rst_b_in, .hold_n_in, .bipolar_in, .comp_over_ref_in,
  .result_out, .trial_out, .held_sample_out, .tracking_out,
  .msb_to_ref_out, .eoc_n_out, .track_done_n_out, .calibrating_out);
`default_nettype wire

// ==== verification/sar_host_model.sv ====
// sampling host and comparator model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_host_model #(parameter int RES = 12) (
  input wire logic clk_in,
  input wire logic [RES-1:0] held_in,
  input wire logic [RES-1:0] trial_in,
  output logic hold_n_out,
  output logic below_out
);
  initial hold_n_out = 1'b1;
  // trapped charge against the trial level
  assign below_out = held_in < trial_in;
  // low for n clocks; long n overruns the conversion on purpose
  task automatic pulse(input int n);
    @(posedge clk_in);
    #1 hold_n_out = 1'b0;
    repeat (n) @(posedge clk_in);
    #1 hold_n_out = 1'b1;
  endtask
endmodule // sar_host_model
`default_nettype wire

// ==== verification/sar_conversion_sequencer_tb_top.sv ====
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer_tb_top;
  localparam int RES = 12;
  logic clk = 0, rst_b = 0, mck = 0, osc = 0, ph = 0, ph2 = 0, ext = 0;
  logic hold_n, below, bip = 0, over = 0, under = 0;
  logic trk, m2r, eoc_n, tdn, cal;
  logic [RES-1:0] analog_input = 0, off = 0, result, trial, held;
  logic [7:0] trim;
  int mc = 0, fails = 0, total_checks = 0, t, s;
  initial forever #5 clk = ~clk;
  // oscillator tick, or a 40 ns pin clock once ext is set
  always @(posedge clk) begin
    #1 ph = ~ph;
    if (ph) ph2 = ~ph2;
    osc = ph & ~ext;
    mck = ph2 & ext;
    if (ext ? ph & ph2 : ph) mc++;
  end
  sar_conversion_sequencer #(.RES(RES), .CAL_CYCLES(64)) i_dut (
    .sys_clk_in(clk), .rst_b_in(rst_b), .master_clock_in(mck),
    .osc_tick_in(osc), .hold_n_in(hold_n), .bipolar_in(bip),
    .cal_start_in(1'b0), .comp_below_in(below),
    .comp_over_ref_in(over), .comp_under_range_in(under),
    .analog_input_code_in(analog_input), .comp_offset_in(off),
    .result_out(result), .trial_out(trial), .tracking_out(trk),
    .msb_to_ref_out(m2r), .eoc_n_out(eoc_n), .track_done_n_out(tdn),
    .calibrating_out(cal), .cal_trim_out(trim), .held_sample_out(held));
  sar_host_model #(.RES(RES)) i_host (.clk_in(clk), .held_in(held),
    .trial_in(trial), .hold_n_out(hold_n), .below_out(below));
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, want, seen);
    end
  endtask
  // sel: 0 end of conversion, 1 track done, 2 tracking
  task automatic wait_on(input int sel, input logic v);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? eoc_n : sel == 1 ? tdn : trk) === v) return;
    end
    fails++;
    final_report();
  endtask
  task automatic convert(input logic [RES-1:0] v, input int n);
    repeat (240) @(posedge clk);
    #1 analog_input = v;
    s = mc;
    fork i_host.pulse(n); join_none
    wait_on(2, 1'b0);
    analog_input = ~v;
    wait_on(0, 1'b0);
    t = mc - s;
  endtask
  task automatic t_unipolar;
    off = 12'h003;
    convert(12'hA5C, 10);
    check("result", result, 16'h0A59);
    check("held", held, 16'h0A59);
    check("tracking", trk, 16'h0001);
    check("msb to ref", m2r, 16'h0000);
    // 14 ticks plus pin sync and up to one tick of start delay
    check("conv length", 16'(t >= 49 && t <= 63), 16'h0001);
    s = mc;
    wait_on(1, 1'b0);
    check("track done", 16'(mc - s >= 14 && mc - s <= 18), 16'h0001);
  endtask
  task automatic t_bipolar;
    bip = 1'b1;
    repeat (4) @(posedge clk);
    #1 check("bipolar msb", m2r, 16'h0001);
    convert(12'h3E1, 10);
    check("bipolar result", result, 16'h03DE);
    bip = 1'b0;
  endtask
  task automatic t_saturate;
    for (int i = 0; i < 2; i++) begin
      over = i == 0;
      under = i == 1;
      convert(12'h555, 10);
      check("saturate", result, i == 0 ? 16'h0FFF : 16'h0000);
    end
    over = 1'b0;
    under = 1'b0;
  endtask
  task automatic t_hold_long;
    convert(12'h123, 150);
    wait_on(2, 1'b0);
    check("restart trial", trial, 16'h0800);
    wait_on(0, 1'b0);
    check("second result", result, 16'h0ED9);
  endtask
  task automatic t_ext;
    ext = 1'b1;
    convert(12'h0F0, 10);
    check("ext result", result, 16'h00ED);
    check("ext length", 16'(t >= 49 && t <= 63), 16'h0001);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 check("trim reset", trim, 16'h0080);
    rst_b = 1'b1;
    // hold during calibration must be dropped
    fork i_host.pulse(10); join_none
    wait_on(0, 1'b0);
    check("calibrating", cal, 16'h0000);
    repeat (40) @(posedge clk);
    #1 check("still tracking", trk, 16'h0001);
    t_unipolar();
    t_bipolar();
    t_saturate();
    t_hold_long();
    t_ext();
    final_report();
  end
endmodule // sar_conversion_sequencer_tb_top
`default_nettype wire
